// ---- hw/ctfc_pkg.sv ----
`default_nettype none
package ctfc_pkg;

	// Register byte addresses
	localparam logic [23:0] ADDR_CTRL       = 24'h1c0008;
	localparam logic [23:0] ADDR_TIMER      = 24'h1c000c;
	localparam logic [23:0] ADDR_SHARED_MSK = 24'h1c0010;
	localparam logic [23:0] ADDR_BUF14_MSK  = 24'h1c0014;
	localparam logic [23:0] ADDR_BUF15_MSK  = 24'h1c0018;
	localparam logic [23:0] ADDR_FAULT_CNT  = 24'h1c001c;

	// Field positions
	localparam int CTRL_TSYNC_BIT  = 0;
	localparam int CTRL_STATE_LSB  = 4;
	localparam int CNT_REC_LSB     = 8;
	localparam int CNT_TEC_LSB     = 0;
	localparam int MASK_BASE_MSB   = 28;
	localparam int MASK_BASE_LSB   = 18;
	localparam int MASK_EXT_MSB    = 17;

	// Values after reset
	localparam logic [15:0] TIMER_RST = 16'h0000;
	localparam logic [28:0] MASK_RST  = 29'h00000000;
	localparam logic [7:0]  CNT_RST   = 8'h00;

	// Fault confinement figures
	localparam logic [7:0] PASSIVE_LIMIT = 8'h80;
	localparam logic [8:0] TEC_MAX       = 9'h0ff;
	localparam logic [7:0] REC_RESUME    = 8'h77;
	localparam logic [7:0] RECOVER_TEC   = 8'h80;
	localparam logic [3:0] RECESSIVE_RUN = 4'hb;
	localparam logic [7:0] ERR_STEP_BIG  = 8'h08;
	localparam logic [7:0] ERR_STEP_ONE  = 8'h01;

	// Confinement state codes
	localparam logic [1:0] CONF_ACTIVE  = 2'h0;
	localparam logic [1:0] CONF_PASSIVE = 2'h1;
	localparam logic [1:0] CONF_BUSOFF  = 2'h2;

	// Buffers with a mask of their own, and the sync buffer
	localparam logic [3:0] BUF_OWN14 = 4'he;
	localparam logic [3:0] BUF_OWN15 = 4'hf;
	localparam logic [3:0] BUF_SYNC  = 4'h0;

	typedef enum logic [1:0] {
		FC_ACTIVE,
		FC_PASSIVE,
		FC_BUSOFF
	} ctfc_conf_t;

endpackage : ctfc_pkg
`default_nettype wire

// ---- hw/ctfc_accept_match.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctfc_accept_match (
	// Mask in force for the buffer
	input  wire logic [28:0] mask,
	// Buffer identifier
	input  wire logic [28:0] buf_id,
	input  wire logic        buf_ide,
	// Incoming identifier
	input  wire logic [28:0] rx_id,
	input  wire logic        rx_ide,
	// Result
	output var  logic        match
);

	wire logic [28:0] id_compare_bit;
	wire logic        base_ok;
	wire logic        ext_ok;

	assign id_compare_bit = mask & (rx_id ^ buf_id); // [RULE_07]
	assign base_ok = id_compare_bit[ctfc_pkg::MASK_BASE_MSB:
		ctfc_pkg::MASK_BASE_LSB] == 11'h000; // [RULE_08]
	assign ext_ok = !rx_ide ||
		id_compare_bit[ctfc_pkg::MASK_EXT_MSB:0] == 18'h00000; // [RULE_08]
	assign match = (rx_ide == buf_ide) && base_ok && ext_ok; // [RULE_23]

endmodule : ctfc_accept_match
`default_nettype wire

// ---- hw/ctfc_top.sv ----
// Function
// [RULE_01] Sixteen-bit timer, zero at reset, wraps
// [RULE_02] Timer steps once per bus bit time
// [RULE_03] Timer holds still in freeze mode
// [RULE_04] Capture at ID start, store on success
// [RULE_05] Timer write via holding register, handshake
// [RULE_06] Shared mask 0-13, own masks 14, 15
// [RULE_07] Mask zero ignores bit, one compares
// [RULE_08] Bits 28-18 always, 17-0 extended only
// [RULE_09] Software changes masks only when frozen; the code accepts mask writes in any mode
// [RULE_10] Receive count 15-8, transmit count 7-0
// [RULE_11] Counters follow CAN increment, decrement rules
// [RULE_12] Counters writable by software only frozen
// [RULE_13] Counter write via holding register, handshake
// [RULE_14] Count at 128 or more: passive
// [RULE_15] Both counts 127 or less: active
// [RULE_16] Transmit overflow: bus-off, event, clear count
// [RULE_17] Eleven recessive bits step recovery to 128
// [RULE_18] Dominant bit restarts recessive run count
// [RULE_19] Passive: acknowledge errors stop counting
// [RULE_20] Receive count stalls above 127, reloads
// [RULE_21] Flags, transmit delay, silence by state; the code has the flags and bus_drive_enable silence, no transmit delay
// [RULE_22] Sync mode clears timer on buffer 0
// [RULE_23] Extension bit and unmasked bits must match
//
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ctfc_top (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        arst_n,
	// Avalon-MM slave
	input  wire logic [23:0] address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	input  wire logic [3:0]  byteenable,
	output var  logic [31:0] readdata,
	output var  logic        waitrequest,
	// Controller status
	input  wire logic        freeze_mode,
	input  wire logic        bit_tick,
	input  wire logic        bus_bit,
	// Frame events
	input  wire logic        id_start,
	input  wire logic        frame_ok,
	input  wire logic        frame_is_rx,
	input  wire logic [3:0]  frame_buf,
	// Error events
	input  wire logic        rx_err_one,
	input  wire logic        rx_err_big,
	input  wire logic        tx_err_big,
	input  wire logic        ack_fault_flag,
	// Acceptance compare request
	input  wire logic [3:0]  cmp_buf,
	input  wire logic [28:0] cmp_buf_id,
	input  wire logic        cmp_buf_ide,
	input  wire logic [28:0] cmp_rx_id,
	input  wire logic        cmp_rx_ide,
	output var  logic        cmp_match,
	// Timestamp write to message buffer
	output var  logic        stamp_wr,
	output var  logic [3:0]  stamp_buf,
	output var  logic [15:0] stamp_val,
	// Fault confinement
	output var  logic [1:0]  confinement_state,
	output var  logic        bus_off_event,
	output var  logic        bus_drive_enable,
	output var  logic        passive_mode
);

	function automatic logic [31:0] be_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : be_merge

	////////////////////////////////////////////////////////////////////
	// Registers

	logic [31:0]             readdata_q;
	logic                    waitrequest_q;
	logic                    tsync_q;
	logic [15:0]             timer_q;
	logic [15:0]             timer_hold_q;
	logic                    timer_req_q;
	logic [15:0]             cap_q;
	logic [28:0]             msk_shared_q;
	logic [28:0]             msk_b14_q;
	logic [28:0]             msk_b15_q;
	logic [7:0]              transmit_error_count_q;
	logic [7:0]              receive_error_count_q;
	logic [15:0]             cnt_hold_q;
	logic                    cnt_req_q;
	logic [3:0]              run_q;
	ctfc_pkg::ctfc_conf_t    state_q;
	logic                    cmp_match_q;
	logic                    stamp_wr_q;
	logic [3:0]              stamp_buf_q;
	logic [15:0]             stamp_val_q;
	logic [1:0]              conf_code_q;
	logic                    bus_off_event_q;
	logic                    bus_drive_q;
	logic                    passive_q;

	////////////////////////////////////////////////////////////////////
	// Bus decode

	wire logic        req;
	wire logic        wr_take;
	wire logic        sel_ctrl;
	wire logic        sel_timer;
	wire logic        sel_shared;
	wire logic        sel_b14;
	wire logic        sel_b15;
	wire logic        sel_cnt;
	wire logic [31:0] rd_ctrl;
	wire logic [31:0] rd_timer;
	wire logic [31:0] rd_cnt;
	wire logic [31:0] rd_mux;
	wire logic [31:0] timer_wr;
	wire logic [31:0] cnt_wr;
	wire logic [31:0] ctrl_wr;
	wire logic [31:0] shared_wr;
	wire logic [31:0] b14_wr;
	wire logic [31:0] b15_wr;

	assign req        = read || write;
	assign wr_take    = write && !waitrequest_q;
	assign sel_ctrl   = address == ctfc_pkg::ADDR_CTRL;
	assign sel_timer  = address == ctfc_pkg::ADDR_TIMER;
	assign sel_shared = address == ctfc_pkg::ADDR_SHARED_MSK;
	assign sel_b14    = address == ctfc_pkg::ADDR_BUF14_MSK;
	assign sel_b15    = address == ctfc_pkg::ADDR_BUF15_MSK;
	assign sel_cnt    = address == ctfc_pkg::ADDR_FAULT_CNT;

	assign rd_ctrl = (32'(tsync_q) << ctfc_pkg::CTRL_TSYNC_BIT) |
		(32'(conf_code_q) << ctfc_pkg::CTRL_STATE_LSB);
	assign rd_timer = {16'h0000, timer_q};
	assign rd_cnt = {16'h0000, receive_error_count_q,
		transmit_error_count_q}; // [RULE_10]
	assign rd_mux = sel_ctrl   ? rd_ctrl :
	                sel_timer  ? rd_timer :
	                sel_shared ? {3'h0, msk_shared_q} :
	                sel_b14    ? {3'h0, msk_b14_q} :
	                sel_b15    ? {3'h0, msk_b15_q} :
	                sel_cnt    ? rd_cnt : 32'h00000000;

	assign timer_wr  = be_merge(rd_timer, writedata, byteenable);
	assign cnt_wr    = be_merge(rd_cnt, writedata, byteenable);
	assign ctrl_wr   = be_merge(rd_ctrl, writedata, byteenable);
	assign shared_wr = be_merge({3'h0, msk_shared_q}, writedata, byteenable);
	assign b14_wr    = be_merge({3'h0, msk_b14_q}, writedata, byteenable);
	assign b15_wr    = be_merge({3'h0, msk_b15_q}, writedata, byteenable);

	// One wait cycle, then the answer for one cycle
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			waitrequest_q <= 1'b1;
			readdata_q    <= 32'h00000000;
		end else begin
			waitrequest_q <= !(req && waitrequest_q);
			readdata_q    <= (read && waitrequest_q) ? rd_mux : readdata_q;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tsync_q      <= 1'b0;
			msk_shared_q <= ctfc_pkg::MASK_RST;
			msk_b14_q    <= ctfc_pkg::MASK_RST;
			msk_b15_q    <= ctfc_pkg::MASK_RST;
		end else if (wr_take) begin
			if (sel_ctrl) begin
				tsync_q <= ctrl_wr[ctfc_pkg::CTRL_TSYNC_BIT];
			end
			if (sel_shared) begin
				msk_shared_q <= shared_wr[28:0]; // [RULE_08]
			end
			if (sel_b14) begin
				msk_b14_q <= b14_wr[28:0];
			end
			if (sel_b15) begin
				msk_b15_q <= b15_wr[28:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Holding registers and request/acknowledge

	wire logic cnt_wr_ok;

	assign cnt_wr_ok = wr_take && sel_cnt && freeze_mode; // [RULE_12]

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			timer_hold_q <= ctfc_pkg::TIMER_RST;
			timer_req_q  <= 1'b0;
			cnt_hold_q   <= 16'h0000;
			cnt_req_q    <= 1'b0;
		end else begin
			timer_req_q <= wr_take && sel_timer; // [RULE_05]
			cnt_req_q   <= cnt_wr_ok; // [RULE_13]
			if (wr_take && sel_timer) begin
				timer_hold_q <= timer_wr[15:0]; // [RULE_05]
			end
			if (cnt_wr_ok) begin
				cnt_hold_q <= cnt_wr[15:0]; // [RULE_13]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Timestamp timer

	wire logic sync_clear;

	assign sync_clear = tsync_q && frame_ok && frame_is_rx &&
		frame_buf == ctfc_pkg::BUF_SYNC; // [RULE_22]

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			timer_q <= ctfc_pkg::TIMER_RST; // [RULE_01]
		end else if (sync_clear) begin
			timer_q <= ctfc_pkg::TIMER_RST; // [RULE_22]
		end else if (timer_req_q) begin
			timer_q <= timer_hold_q; // [RULE_05]
		end else if (bit_tick && !freeze_mode) begin // [RULE_02] [RULE_03]
			timer_q <= timer_q + 16'h0001; // [RULE_01]
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cap_q       <= ctfc_pkg::TIMER_RST;
			stamp_wr_q  <= 1'b0;
			stamp_buf_q <= 4'h0;
			stamp_val_q <= ctfc_pkg::TIMER_RST;
		end else begin
			stamp_wr_q <= frame_ok; // [RULE_04]
			if (id_start) begin
				cap_q <= timer_q; // [RULE_04]
			end
			if (frame_ok) begin
				stamp_buf_q <= frame_buf;
				stamp_val_q <= cap_q; // [RULE_04]
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Acceptance masks

	wire logic [28:0] mask_sel;
	wire logic        match_w;

	assign mask_sel = (cmp_buf == ctfc_pkg::BUF_OWN15) ? msk_b15_q :
	                  (cmp_buf == ctfc_pkg::BUF_OWN14) ? msk_b14_q :
	                  msk_shared_q; // [RULE_06]

	ctfc_accept_match u_match (
		.mask    (mask_sel),
		.buf_id  (cmp_buf_id),
		.buf_ide (cmp_buf_ide),
		.rx_id   (cmp_rx_id),
		.rx_ide  (cmp_rx_ide),
		.match   (match_w)
	);

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cmp_match_q <= 1'b0;
		end else begin
			cmp_match_q <= match_w; // [RULE_23]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Error counters and confinement state

	logic [7:0]           tec_d;
	logic [7:0]           rec_d;
	logic [3:0]           run_d;
	logic                 boff_evt_d;
	logic [8:0]           tec_sum;
	ctfc_pkg::ctfc_conf_t state_d;

	always_comb begin
		tec_d      = transmit_error_count_q;
		rec_d      = receive_error_count_q;
		run_d      = run_q;
		state_d    = state_q;
		boff_evt_d = 1'b0;
		tec_sum    = {1'b0, transmit_error_count_q};
		unique case (state_q)
			ctfc_pkg::FC_BUSOFF: begin
				if (bit_tick && !bus_bit) begin
					run_d = 4'h0; // [RULE_18]
				end else if (bit_tick) begin
					run_d = run_q + 4'h1; // [RULE_17]
					if (run_d == ctfc_pkg::RECESSIVE_RUN) begin
						run_d = 4'h0;
						tec_d = transmit_error_count_q + 8'h01; // [RULE_17]
						if (tec_d == ctfc_pkg::RECOVER_TEC) begin
							tec_d   = ctfc_pkg::CNT_RST; // [RULE_17]
							rec_d   = ctfc_pkg::CNT_RST;
							state_d = ctfc_pkg::FC_ACTIVE;
						end
					end
				end
			end
			ctfc_pkg::FC_ACTIVE, ctfc_pkg::FC_PASSIVE: begin
				// Receive side
				if (rx_err_one || rx_err_big) begin
					if (receive_error_count_q < ctfc_pkg::PASSIVE_LIMIT) begin
						rec_d = receive_error_count_q + (rx_err_big ?
							ctfc_pkg::ERR_STEP_BIG :
							ctfc_pkg::ERR_STEP_ONE); // [RULE_11]
					end // [RULE_20]
				end else if (frame_ok && frame_is_rx) begin
					if (receive_error_count_q >= ctfc_pkg::PASSIVE_LIMIT) begin
						rec_d = ctfc_pkg::REC_RESUME; // [RULE_20]
					end else if (receive_error_count_q != 8'h00) begin
						rec_d = receive_error_count_q - 8'h01; // [RULE_11]
					end
				end
				// Transmit side
				if (tx_err_big && !(ack_fault_flag &&
					state_q == ctfc_pkg::FC_PASSIVE)) begin // [RULE_19]
					tec_sum = {1'b0, transmit_error_count_q} +
						{1'b0, ctfc_pkg::ERR_STEP_BIG}; // [RULE_11]
					tec_d = tec_sum[7:0];
				end else if (frame_ok && !frame_is_rx &&
					transmit_error_count_q != 8'h00) begin
					tec_d = transmit_error_count_q - 8'h01; // [RULE_11]
				end
				if (tec_sum > ctfc_pkg::TEC_MAX) begin
					state_d    = ctfc_pkg::FC_BUSOFF; // [RULE_16]
					tec_d      = ctfc_pkg::CNT_RST;
					run_d      = 4'h0;
					boff_evt_d = 1'b1;
				end else if (tec_d >= ctfc_pkg::PASSIVE_LIMIT ||
					rec_d >= ctfc_pkg::PASSIVE_LIMIT) begin
					state_d = ctfc_pkg::FC_PASSIVE; // [RULE_14]
				end else begin
					state_d = ctfc_pkg::FC_ACTIVE; // [RULE_15]
				end
			end
			default: begin
				state_d = ctfc_pkg::FC_ACTIVE;
			end
		endcase
		if (cnt_req_q) begin
			tec_d = cnt_hold_q[ctfc_pkg::CNT_TEC_LSB +: 8]; // [RULE_13]
			rec_d = cnt_hold_q[ctfc_pkg::CNT_REC_LSB +: 8];
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			transmit_error_count_q <= ctfc_pkg::CNT_RST;
			receive_error_count_q  <= ctfc_pkg::CNT_RST;
			run_q                  <= 4'h0;
			state_q                <= ctfc_pkg::FC_ACTIVE;
			bus_off_event_q        <= 1'b0;
		end else begin
			transmit_error_count_q <= tec_d;
			receive_error_count_q  <= rec_d;
			run_q                  <= run_d;
			state_q                <= state_d;
			bus_off_event_q        <= boff_evt_d; // [RULE_16]
		end
	end

	wire logic [1:0] conf_code_d;

	assign conf_code_d =
		(state_d == ctfc_pkg::FC_BUSOFF)  ? ctfc_pkg::CONF_BUSOFF :
		(state_d == ctfc_pkg::FC_PASSIVE) ? ctfc_pkg::CONF_PASSIVE :
		ctfc_pkg::CONF_ACTIVE;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			conf_code_q <= ctfc_pkg::CONF_ACTIVE;
			bus_drive_q <= 1'b1;
			passive_q   <= 1'b0;
		end else begin
			conf_code_q <= conf_code_d; // [RULE_14]
			bus_drive_q <= state_d != ctfc_pkg::FC_BUSOFF; // [RULE_21]
			passive_q   <= state_d == ctfc_pkg::FC_PASSIVE; // [RULE_21]
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign readdata          = readdata_q;
	assign waitrequest       = waitrequest_q;
	assign cmp_match         = cmp_match_q;
	assign stamp_wr          = stamp_wr_q;
	assign stamp_buf         = stamp_buf_q;
	assign stamp_val         = stamp_val_q;
	assign confinement_state = conf_code_q;
	assign bus_off_event     = bus_off_event_q;
	assign bus_drive_enable  = bus_drive_q;
	assign passive_mode      = passive_q;

endmodule : ctfc_top
`default_nettype wire

// ---- bench/ctfc_bus_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctfc_bus_model (
	// Clock and reset
	input  wire logic clock,
	input  wire logic arst_n,
	// Bench control
	input  wire logic run,
	input  wire logic level,
	// Bit stream seen by the node
	output var  logic bit_tick,
	output var  logic bus_bit
);
	logic [1:0] div_q;
	wire        tick_d = run && div_q == 2'h3;
	// Between bit samples the line level is not meaningful, so it toggles
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			div_q    <= 2'h0;
			bit_tick <= 1'h0;
			bus_bit  <= 1'h1;
		end else begin
			div_q    <= div_q + 2'h1;
			bit_tick <= tick_d;
			bus_bit  <= tick_d ? level : ~bus_bit;
		end
	end
endmodule : ctfc_bus_model
`default_nettype wire

// ---- bench/ctfc_top_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctfc_top_checker (
	// Clock and reset
	input wire logic        clock,
	input wire logic        arst_n,
	// Watched ports
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest,
	input wire logic        frame_ok,
	input wire logic [3:0]  frame_buf,
	input wire logic        bit_tick,
	input wire logic        cmp_buf_ide,
	input wire logic        cmp_rx_ide,
	input wire logic [28:0] cmp_buf_id,
	input wire logic [28:0] cmp_rx_id,
	input wire logic        cmp_match,
	input wire logic        stamp_wr,
	input wire logic [3:0]  stamp_buf,
	input wire logic [1:0]  confinement_state,
	input wire logic        bus_off_event,
	input wire logic        bus_drive_enable,
	input wire logic        passive_mode
);
	default clocking @(posedge clock); endclocking
	default disable iff (!arst_n);
	wire boff = confinement_state == 2'h2;
	////////////////////////////////////////
	a_wait_one: assert property (
		(read || write) && waitrequest |=> !waitrequest)
		else $error("no answer one cycle after request");
	a_wait_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("answer longer than one cycle");
	a_stamp_follow: assert property (
		frame_ok |=> stamp_wr && stamp_buf == $past(frame_buf))
		else $error("stamp write missing after frame");
	a_stamp_cause: assert property (
		stamp_wr |-> $past(frame_ok))
		else $error("stamp write without frame");
	a_drive_off: assert property (
		boff == !bus_drive_enable)
		else $error("bus drive does not follow bus-off");
	a_passive_flag: assert property (
		passive_mode == (confinement_state == 2'h1))
		else $error("passive flag does not follow state");
	a_event_entry: assert property (
		bus_off_event == $rose(boff))
		else $error("bus-off event not on entry");
	a_ide_differ: assert property (
		cmp_buf_ide != cmp_rx_ide |=> !cmp_match)
		else $error("match despite extension bit");
	a_same_id: assert property (
		cmp_buf_ide == cmp_rx_ide && cmp_buf_id == cmp_rx_id |=> cmp_match)
		else $error("equal identifiers not matched");
	a_busoff_hold: assert property (
		boff && !bit_tick |=> boff)
		else $error("left bus-off without a bit");
	c_busoff: cover property (bus_off_event);
	c_recover: cover property ($fell(boff));
	c_stamp: cover property (stamp_wr);
	c_match: cover property (cmp_match);
endmodule : ctfc_top_checker
bind ctfc_top ctfc_top_checker u_chk (.clock, .arst_n, .read, .write,
	.waitrequest, .frame_ok, .frame_buf, .bit_tick, .cmp_buf_ide, .cmp_rx_ide,
	.cmp_buf_id, .cmp_rx_id, .cmp_match, .stamp_wr, .stamp_buf,
	.confinement_state, .bus_off_event, .bus_drive_enable, .passive_mode);
`default_nettype wire

// ---- bench/ctfc_top_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctfc_top_tb;
	logic        clock, arst_n, read, write, waitrequest, freeze_mode;
	logic        bit_tick, bus_bit, id_start, frame_ok, frame_is_rx, run;
	logic        rx_err_one, rx_err_big, tx_err_big, ack_fault_flag, level;
	logic        cmp_buf_ide, cmp_rx_ide, cmp_match, stamp_wr, passive_mode;
	logic        bus_off_event, bus_drive_enable;
	logic [23:0] address;
	logic [31:0] writedata, readdata, q;
	logic [3:0]  byteenable, frame_buf, cmp_buf, stamp_buf;
	logic [28:0] cmp_buf_id, cmp_rx_id;
	logic [15:0] stamp_val;
	logic [1:0]  confinement_state;
	int          n_fail, n_compared, cycles;
	ctfc_top dut (.clock, .arst_n, .address, .read, .write, .writedata,
		.byteenable, .readdata, .waitrequest, .freeze_mode, .bit_tick,
		.bus_bit, .id_start, .frame_ok, .frame_is_rx, .frame_buf, .rx_err_one,
		.rx_err_big, .tx_err_big, .ack_fault_flag, .cmp_buf, .cmp_buf_id,
		.cmp_buf_ide, .cmp_rx_id, .cmp_rx_ide, .cmp_match, .stamp_wr,
		.stamp_buf, .stamp_val, .confinement_state, .bus_off_event,
		.bus_drive_enable, .passive_mode);
	ctfc_bus_model u_bus (.clock, .arst_n, .run, .level, .bit_tick, .bus_bit);
	////////////////////////////////////////
	task final_report;
		$display("failures %0d comparisons %0d", n_fail, n_compared);
		if (n_fail == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : final_report
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task bus(input logic w, input logic [23:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clock);
		address    <= a;
		read       <= !w;
		write      <= w;
		writedata  <= d;
		byteenable <= be;
		@(posedge clock);
		while (waitrequest !== 1'h0) @(posedge clock);
		q = readdata;
		read  <= 1'h0;
		write <= 1'h0;
	endtask : bus
	task wr(input logic [23:0] a, input logic [31:0] d);
		bus(1'h1, a, d, 4'hf);
	endtask : wr
	task rd(input logic [23:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0, 4'hf);
		chk(q, e);
	endtask : rd
	task ticks(input int n, input logic lv);
		@(posedge clock);
		run   <= 1'h1;
		level <= lv;
		repeat (n) begin
			@(posedge clock);
			while (bit_tick !== 1'h1) @(posedge clock);
		end
		run <= 1'h0;
	endtask : ticks
	task cmpt(input logic [3:0] bn, input logic bi, input logic ri,
		input logic [28:0] x, input logic e);
		@(posedge clock);
		cmp_buf     <= bn;
		cmp_buf_ide <= bi;
		cmp_rx_ide  <= ri;
		cmp_buf_id  <= 29'h0aaaaaaa;
		cmp_rx_id   <= 29'h0aaaaaaa ^ x;
		@(posedge clock);
		@(negedge clock);
		chk(32'(cmp_match), 32'(e));
	endtask : cmpt
	////////////////////////////////////////
	task t_reset;
		rd(ctfc_pkg::ADDR_TIMER, 32'h0);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h0);
		wr(24'h1c0004, 32'hffffffff);
		rd(24'h1c0004, 32'h0);
		chk(32'(bus_drive_enable), 32'h1);
	endtask : t_reset
	task t_timer;
		freeze_mode <= 1'h1;
		wr(ctfc_pkg::ADDR_TIMER, 32'h0000fffe);
		rd(ctfc_pkg::ADDR_TIMER, 32'h0000fffe);
		ticks(4, 1'h1);
		rd(ctfc_pkg::ADDR_TIMER, 32'h0000fffe);
		freeze_mode <= 1'h0;
		ticks(3, 1'h1);
		rd(ctfc_pkg::ADDR_TIMER, 32'h1);
		@(posedge clock);
		id_start <= 1'h1;
		@(posedge clock);
		id_start <= 1'h0;
		ticks(2, 1'h1);
		@(posedge clock);
		frame_buf <= 4'h5;
		frame_ok  <= 1'h1;
		@(posedge clock);
		frame_ok <= 1'h0;
		@(negedge clock);
		chk(32'(stamp_wr), 32'h1);
		chk(32'(stamp_val), 32'h1);
		chk(32'(stamp_buf), 32'h5);
		rd(ctfc_pkg::ADDR_TIMER, 32'h3);
	endtask : t_timer
	task t_mask;
		freeze_mode <= 1'h1;
		bus(1'h1, ctfc_pkg::ADDR_BUF15_MSK, 32'hffffffff, 4'h1);
		rd(ctfc_pkg::ADDR_BUF15_MSK, 32'h000000ff);
		wr(ctfc_pkg::ADDR_BUF14_MSK, 32'hffffffff);
		rd(ctfc_pkg::ADDR_BUF14_MSK, 32'h1fffffff);
		wr(ctfc_pkg::ADDR_BUF14_MSK, 32'h0);
		wr(ctfc_pkg::ADDR_SHARED_MSK, 32'h1ffc0000);
		wr(ctfc_pkg::ADDR_BUF15_MSK, 32'h1);
		freeze_mode <= 1'h0;
		cmpt(4'h3, 1'h1, 1'h1, 29'h00000123, 1'h1);
		cmpt(4'h3, 1'h1, 1'h1, 29'h00040000, 1'h0);
		cmpt(4'hd, 1'h1, 1'h0, 29'h00000000, 1'h0);
		cmpt(4'he, 1'h1, 1'h1, 29'h1fffffff, 1'h1);
		cmpt(4'hf, 1'h0, 1'h0, 29'h00000001, 1'h1);
		cmpt(4'hf, 1'h1, 1'h1, 29'h00000001, 1'h0);
		cmpt(4'hf, 1'h1, 1'h1, 29'h00040000, 1'h1);
	endtask : t_mask
	task t_tx;
		wr(ctfc_pkg::ADDR_FAULT_CNT, 32'h505);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h0);
		freeze_mode <= 1'h1;
		wr(ctfc_pkg::ADDR_FAULT_CNT, 32'hf0);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'hf0);
		chk(32'(passive_mode), 32'h1);
		freeze_mode <= 1'h0;
		@(posedge clock);
		tx_err_big     <= 1'h1;
		ack_fault_flag <= 1'h1;
		@(posedge clock);
		ack_fault_flag <= 1'h0;
		@(posedge clock);
		tx_err_big <= 1'h0;
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'hf8);
		@(posedge clock);
		tx_err_big <= 1'h1;
		@(posedge clock);
		tx_err_big <= 1'h0;
		@(negedge clock);
		chk(32'(bus_off_event), 32'h1);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h0);
		chk(32'(confinement_state), 32'h2);
		chk(32'(bus_drive_enable), 32'h0);
		rd(ctfc_pkg::ADDR_CTRL, 32'h20);
		ticks(11, 1'h1);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h1);
		ticks(5, 1'h1);
		ticks(1, 1'h0);
		ticks(10, 1'h1);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h1);
		ticks(1, 1'h1);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h2);
		ticks(1375, 1'h1);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h7f);
		ticks(11, 1'h1);
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h0);
		chk(32'(confinement_state), 32'h0);
	endtask : t_tx
	task t_rx;
		freeze_mode <= 1'h1;
		wr(ctfc_pkg::ADDR_CTRL, 32'h1);
		wr(ctfc_pkg::ADDR_FAULT_CNT, 32'h7e00);
		freeze_mode <= 1'h0;
		@(posedge clock);
		rx_err_big <= 1'h1;
		@(posedge clock);
		rx_err_big <= 1'h0;
		@(negedge clock);
		chk(32'(passive_mode), 32'h1);
		@(posedge clock);
		rx_err_one <= 1'h1;
		@(posedge clock);
		rx_err_one <= 1'h0;
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h8600);
		@(posedge clock);
		frame_is_rx <= 1'h1;
		frame_buf   <= 4'h0;
		frame_ok    <= 1'h1;
		@(posedge clock);
		frame_ok <= 1'h0;
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h7700);
		chk(32'(confinement_state), 32'h0);
		rd(ctfc_pkg::ADDR_TIMER, 32'h0);
	endtask : t_rx
	// Receive error beats receive success; then a sent frame steps down
	task t_count;
		freeze_mode <= 1'h1;
		wr(ctfc_pkg::ADDR_FAULT_CNT, 32'h7703);
		freeze_mode <= 1'h0;
		@(posedge clock);
		frame_ok   <= 1'h1;
		rx_err_one <= 1'h1;
		@(posedge clock);
		frame_is_rx <= 1'h0;
		rx_err_one  <= 1'h0;
		@(posedge clock);
		frame_ok <= 1'h0;
		rd(ctfc_pkg::ADDR_FAULT_CNT, 32'h7802);
		chk(32'(confinement_state), 32'h0);
	endtask : t_count
	////////////////////////////////////////
	initial begin
		clock = 1'h0;
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			final_report();
		end
	end
	initial begin
		{arst_n, read, write, freeze_mode, id_start, frame_ok, frame_is_rx} = '0;
		{rx_err_one, rx_err_big, tx_err_big, ack_fault_flag, run, level} = '0;
		{cmp_buf_ide, cmp_rx_ide, cmp_buf_id, cmp_rx_id, cmp_buf} = '0;
		{address, writedata, frame_buf} = '0;
		byteenable = 4'hf;
		n_fail = 0;
		n_compared = 0;
		cycles = 0;
		repeat (5) @(posedge clock);
		arst_n <= 1'h1;
		t_reset();
		t_timer();
		t_mask();
		t_tx();
		t_rx();
		t_count();
		final_report();
	end
endmodule : ctfc_top_tb
`default_nettype wire
